/* File: design/mcr_pkg.sv */
// constants for the measurement configuration register group
// assumes a byte-wide register port driven by the serial front end
package mcr_pkg;
  localparam logic [7:0] MCR_ADDR_STATUS = 8'h01;
  localparam logic [7:0] MCR_ADDR_PER_HI = 8'h02;
  localparam logic [7:0] MCR_ADDR_PER_LO = 8'h03;
  localparam logic [7:0] MCR_ADDR_CFG    = 8'h04;
  localparam logic [7:0] MCR_RST_PER_HI  = 8'h00;
  localparam logic [7:0] MCR_RST_PER_LO  = 8'h3c;
  localparam logic [7:0] MCR_RST_CFG     = 8'h24;
  localparam logic [3:0] MCR_PER_HI_MAX  = 4'hf;
  localparam logic [7:0] MCR_PER_LO_MIN  = 8'h05;
  localparam logic [11:0] MCR_PER_MIN    = 12'h005;
  localparam logic [11:0] MCR_PER_MAX    = 12'hfff;
  localparam int MCR_HI_W       = 4;
  localparam int MCR_CFG_EN_BIT = 5;
  localparam int MCR_CFG_MD_BIT = 4;
  localparam int MCR_ST_ERR_BIT = 3;
  localparam int MCR_ST_CLR_BIT = 0;
  localparam int MCR_ST_PIN_BIT = 6;
  localparam logic [1:0] MCR_MODE_IDLE = 2'h0;
  localparam logic [1:0] MCR_MODE_CONT = 2'h2;
endpackage

/* File: design/mcr_edge_fall.sv */
// falling edge detector for a synchronous level input
// assumes input already synchronous to clk_sys
module mcr_edge_fall (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic level_in,
  output logic      fall_pulse
);
  typedef struct packed {
    logic prev;
  } mcr_edge_state_t;
  mcr_edge_state_t s_q;
  mcr_edge_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.prev = level_in;
  end

  // reset high so a pin low at reset is taken as an edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q.prev <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign fall_pulse = s_q.prev & ~level_in & clk_en;
endmodule

/* File: design/mcr_regs.sv */
// measurement period and configuration register group
// assumes a one-cycle write strobe and combinational read port
// Behaviour
// - period is high nibble then low byte
// - period above maximum treated as 4095
// - period below five treated as five
// - period latched entering continuous from idle
// - high above 0F flags error, forces 0F
// - low 00 to 04 flags error, forces 05
// - config bit 5 is software output enable
// - output depends on enable and pin
// - pin falling edge sets software enable
// - config bit 4 selects pulse style
// - error sticky until cleared; clear reads zero
module mcr_regs
  import mcr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [1:0]  operating_mode_field,
  input  wire logic        pwm_disable_pin,
  input  wire logic        pwm_wave,
  output logic             pwm_out,
  output logic             pwm_pulse_train,
  output logic      [11:0] active_period,
  output logic             comm_error_flag
);
  import mcr_pkg::*;

  typedef struct packed {
    logic [3:0]  per_hi;
    logic [7:0]  per_lo;
    logic [1:0]  cfg_res;
    logic        pwm_sw_enable;
    logic        pwm_mode;
    logic [1:0]  baseline_comp_config;
    logic [11:0] period;
    logic [1:0]  mode_prev;
    logic        err;
    logic        pwm_out;
  } mcr_state_t;

  mcr_state_t s_q;
  mcr_state_t s_d;
  logic       pin_fall;
  logic [11:0] per_cat;

  mcr_edge_fall u_fall (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .level_in   (pwm_disable_pin),
    .fall_pulse (pin_fall)
  );

  assign per_cat = {s_q.per_hi, s_q.per_lo};

  always_comb begin
    logic set_err;
    logic clr_err;
    set_err = 1'b0;
    clr_err = 1'b0;
    s_d = s_q;
    if (reg_wr) begin
      case (reg_addr)
        MCR_ADDR_PER_HI: begin
          // reserved bits not stored; any set one pushes the byte past 0f
          if (reg_wdata > {4'h0, MCR_PER_HI_MAX}) begin
            s_d.per_hi = MCR_PER_HI_MAX;
            set_err    = 1'b1;
          end else begin
            s_d.per_hi = reg_wdata[MCR_HI_W-1:0];
          end
        end
        MCR_ADDR_PER_LO: begin
          if (reg_wdata < MCR_PER_LO_MIN) begin
            s_d.per_lo = MCR_PER_LO_MIN;
            set_err    = 1'b1;
          end else begin
            s_d.per_lo = reg_wdata;
          end
        end
        MCR_ADDR_CFG: begin
          s_d.cfg_res       = reg_wdata[7:6];
          s_d.pwm_sw_enable = reg_wdata[MCR_CFG_EN_BIT];
          s_d.pwm_mode      = reg_wdata[MCR_CFG_MD_BIT];
          // stored only so the field reads back; its meaning lives elsewhere
          s_d.baseline_comp_config = reg_wdata[3:2];
        end
        MCR_ADDR_STATUS: begin
          clr_err = reg_wdata[MCR_ST_CLR_BIT];
        end
        default: begin
        end
      endcase
    end
    // hardware set wins over a concurrent software write
    if (pin_fall) begin
      s_d.pwm_sw_enable = 1'b1;
    end
    // set wins over clear so no error is lost
    if (set_err) begin
      s_d.err = 1'b1;
    end else if (clr_err) begin
      s_d.err = 1'b0;
    end
    s_d.mode_prev = operating_mode_field;
    if (s_q.mode_prev == MCR_MODE_IDLE &&
        operating_mode_field == MCR_MODE_CONT) begin
      if (per_cat < MCR_PER_MIN) begin
        s_d.period = MCR_PER_MIN;
      end else if (per_cat > MCR_PER_MAX) begin
        s_d.period = MCR_PER_MAX;
      end else begin
        s_d.period = per_cat;
      end
    end
    // output gated by both enable and pin
    s_d.pwm_out = s_q.pwm_sw_enable & ~pwm_disable_pin & pwm_wave;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q.per_hi        <= MCR_RST_PER_HI[MCR_HI_W-1:0];
      s_q.per_lo        <= MCR_RST_PER_LO;
      s_q.cfg_res       <= MCR_RST_CFG[7:6];
      s_q.pwm_sw_enable <= MCR_RST_CFG[MCR_CFG_EN_BIT];
      s_q.pwm_mode      <= MCR_RST_CFG[MCR_CFG_MD_BIT];
      s_q.baseline_comp_config <= MCR_RST_CFG[3:2];
      s_q.period        <= {MCR_RST_PER_HI[MCR_HI_W-1:0], MCR_RST_PER_LO};
      s_q.mode_prev     <= MCR_MODE_IDLE;
      s_q.err           <= 1'b0;
      s_q.pwm_out       <= 1'b0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  always_comb begin
    reg_rdata = 8'h00;
    case (reg_addr)
      MCR_ADDR_PER_HI: reg_rdata = {4'h0, s_q.per_hi};
      MCR_ADDR_PER_LO: reg_rdata = s_q.per_lo;
      MCR_ADDR_CFG: begin
        reg_rdata = {s_q.cfg_res, s_q.pwm_sw_enable, s_q.pwm_mode,
                     s_q.baseline_comp_config, operating_mode_field};
      end
      MCR_ADDR_STATUS: begin
        // clear bit reads zero; only the bits owned here
        reg_rdata[MCR_ST_ERR_BIT] = s_q.err;
        reg_rdata[MCR_ST_PIN_BIT] = pwm_disable_pin;
      end
      default: reg_rdata = 8'h00;
    endcase
  end

  assign pwm_out         = s_q.pwm_out;
  assign pwm_pulse_train = s_q.pwm_mode;
  assign active_period   = s_q.period;
  assign comm_error_flag = s_q.err;
endmodule

/* File: dv/mcr_regs_monitor.sv */
// checker on the mcr_regs ports
// assumes one clock, sync reset
module mcr_regs_monitor (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [1:0]  operating_mode_field,
  input wire logic        pwm_disable_pin,
  input wire logic        pwm_out,
  input wire logic        pwm_pulse_train,
  input wire logic [11:0] active_period,
  input wire logic        comm_error_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // address of a taken write, 00 when idle
  wire logic [7:0] a = reg_wr && clk_en ? reg_addr : 8'h00;
  wire logic       clr = a == 8'h01 && reg_wdata[0];
  a_lo_fix: assert property (a == 8'h03 && reg_wdata < 8'h05
    |=> comm_error_flag) else $error("lo fix");
  a_hi_fix: assert property (a == 8'h02 && reg_wdata > 8'h0f
    |=> comm_error_flag) else $error("hi fix");
  a_per_hold: assert property (clk_en
    && operating_mode_field != 2'h2 |=> $stable(active_period))
    else $error("per moved");
  a_per_min: assert property (active_period >= 12'h005)
    else $error("per low");
  a_err_keep: assert property (comm_error_flag && !clr
    |=> comm_error_flag) else $error("err lost");
  a_err_clr: assert property (clr |=> !comm_error_flag)
    else $error("err kept");
  a_pwm_gate: assert property (clk_en && pwm_disable_pin
    |=> !pwm_out) else $error("pwm on");
  a_pwm_mode: assert property (a == 8'h04
    |=> pwm_pulse_train == $past(reg_wdata[4])) else $error("mode");
  c_latch: cover property ($changed(active_period));
  c_err: cover property ($rose(comm_error_flag));
  c_pin: cover property ($fell(pwm_disable_pin));
endmodule

/* File: dv/mcr_host.sv */
// host model of the register port
// assumes combinational read data
module mcr_host (
  input wire logic       clk_sys,
  output logic           reg_wr,
  output logic     [7:0] reg_addr,
  output logic     [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_wr, reg_addr, reg_wdata} = 17'h00000;
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, v};
    @(posedge clk_sys);
    {reg_wr, reg_wdata} <= {1'b0, ~v}; // stale data not left showing
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] v);
    @(posedge clk_sys) reg_addr <= ad;
    @(negedge clk_sys) v = reg_rdata;
  endtask
endmodule

/* File: dv/mcr_regs_tb.sv */
// bench for the period and config register group
// host model drives the register port
module mcr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    n_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
  logic        clk_sys = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, reg_wr;
  logic        pwm_disable_pin = 1'b0, pwm_wave = 1'b1, pwm_out;
  logic        pwm_pulse_train, comm_error_flag;
  logic [1:0]  operating_mode_field = 2'h0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic [11:0] active_period;
  int          n_errors = 0, comparisons = 0;
  initial forever #50 clk_sys = ~clk_sys;
  mcr_host host (
    .clk_sys   (clk_sys),
    .reg_wr    (reg_wr),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata)
  );
  mcr_regs dut (
    .clk_sys              (clk_sys),
    .sys_rst              (sys_rst),
    .clk_en               (clk_en),
    .reg_wr               (reg_wr),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_rdata            (reg_rdata),
    .operating_mode_field (operating_mode_field),
    .pwm_disable_pin      (pwm_disable_pin),
    .pwm_wave             (pwm_wave),
    .pwm_out              (pwm_out),
    .pwm_pulse_train      (pwm_pulse_train),
    .active_period        (active_period),
    .comm_error_flag      (comm_error_flag)
  );
  task automatic cr(input logic [7:0] ad, input logic [7:0] e);
    host.rd(ad, d);
    `CHK("rdata", e, d)
  endtask
  // idle for two sampled edges, then continuous
  task automatic go_cont;
    @(posedge clk_sys) operating_mode_field <= 2'h0;
    repeat (2) @(posedge clk_sys);
    operating_mode_field <= 2'h2;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic wrap_up;
    $display("%0d checks %0d errors", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cr(8'h03, 8'h3c);
    cr(8'h04, 8'h24);
    host.wr(8'h03, 8'h04);
    cr(8'h03, 8'h05);
    `CHK("err", 1'b1, comm_error_flag)
    host.wr(8'h01, 8'h01);
    cr(8'h01, 8'h00);
    host.wr(8'h02, 8'h1a);
    cr(8'h02, 8'h0f);
    `CHK("err", 1'b1, comm_error_flag)
    host.wr(8'h03, 8'h23);
    @(negedge clk_sys);
    `CHK("per", 12'h03c, active_period)
    go_cont();
    `CHK("per", 12'hf23, active_period)
    host.wr(8'h03, 8'hff);
    @(negedge clk_sys);
    `CHK("per", 12'hf23, active_period)
    go_cont();
    `CHK("per", 12'hfff, active_period)
    host.wr(8'h04, 8'h10);
    cr(8'h04, 8'h12);
    `CHK("pwm", 1'b0, pwm_out)
    @(posedge clk_sys) pwm_disable_pin <= 1'b1;
    @(posedge clk_sys) pwm_disable_pin <= 1'b0;
    repeat (5) @(negedge clk_sys);
    `CHK("pwm", 1'b1, pwm_out)
    @(posedge clk_sys) pwm_disable_pin <= 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK("pwm", 1'b0, pwm_out)
    cr(8'h01, 8'h48);
    @(posedge clk_sys) pwm_disable_pin <= 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK("pwm", 1'b1, pwm_out)
    @(posedge clk_sys) pwm_wave <= 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK("pwm", 1'b0, pwm_out)
    @(posedge clk_sys) pwm_wave <= 1'b1;
    host.wr(8'h01, 8'h01);
    // frozen clock enable: the bad write must neither land nor flag
    @(posedge clk_sys) clk_en <= 1'b0;
    host.wr(8'h03, 8'h01);
    cr(8'h03, 8'hff);
    `CHK("err", 1'b0, comm_error_flag)
    @(posedge clk_sys) clk_en <= 1'b1;
    cr(8'h05, 8'h00);
    wrap_up();
  end
endmodule
bind mcr_regs mcr_regs_monitor mon (
  .clk_sys              (clk_sys),
  .sys_rst              (sys_rst),
  .clk_en               (clk_en),
  .reg_wr               (reg_wr),
  .reg_addr             (reg_addr),
  .reg_wdata            (reg_wdata),
  .operating_mode_field (operating_mode_field),
  .pwm_disable_pin      (pwm_disable_pin),
  .pwm_out              (pwm_out),
  .pwm_pulse_train      (pwm_pulse_train),
  .active_period        (active_period),
  .comm_error_flag      (comm_error_flag)
);
